//--- design/layer_overlay_consts.svh
// Constants for the layer overlay and fine pixel scroll block.
// Assumes it is included by its bare name from design sources only.
`ifndef LAYER_OVERLAY_CONSTS_SVH
`define LAYER_OVERLAY_CONSTS_SVH

// Position and width of the fine scroll field in its command byte.
`define FINE_SCROLL_LSB        0
`define FINE_SCROLL_WIDTH      3
// Position of the two layer mix bits in the overlay command byte.
`define LAYER_MIX_LOW_BIT_POS  0
`define LAYER_MIX_HIGH_BIT_POS 1

// Reset values of the frame-latched settings.
`define FINE_SCROLL_RESET      3'h0
`define LAYER_MIX_RESET        2'h0
`define ADDR_RESET             16'h0000

// Flash half periods, counted in frames.
`define FLASH_SLOW_HALF        6'h11
`define FLASH_FAST_HALF        6'h02
`define FLASH_COUNT_RESET      6'h00

`endif

//--- design/layer_overlay_pkg.sv
// Types shared by the layer overlay and fine pixel scroll block.
// Assumes nothing of its surroundings.
package layer_overlay_pkg;

   typedef enum logic [1:0] {
      MIX_OR      = 2'b00,
      MIX_XOR     = 2'b01,
      MIX_AND     = 2'b10,
      MIX_PRI_OR  = 2'b11
   } layer_mix_e;

   typedef enum logic [1:0] {
      BPP_1       = 2'b00,
      BPP_2       = 2'b01,
      BPP_4       = 2'b10,
      BPP_RSVD    = 2'b11
   } bpp_mode_e;

   typedef enum logic [1:0] {
      ATTR_OFF        = 2'b00,
      ATTR_ON         = 2'b01,
      ATTR_FLASH_SLOW = 2'b10,
      ATTR_FLASH_FAST = 2'b11
   } layer_attr_e;

endpackage

//--- design/layer_overlay_pixel_scroll.sv
// Composes three stacked display layers into one pixel byte stream and
// applies the whole-screen fine horizontal pixel offset.
// Assumes the fetch side presents one byte per layer with byte_strobe,
// and that frame_start and line_start are one-cycle pulses.
//
// Functional notes
// - Shift the shown image left by the 3-bit fine scroll field value.
// - One byte change in block start address moves the image eight pixels.
// - The fine offset applies to the composed image, never per layer.
// - Fine scroll is ignored in two and four bits per pixel modes.
// - Effects come from the layer mix setting and per-layer attributes.
// - Mix bits low one, high zero select exclusive-OR of layers.
`timescale 1ns/100ps
`include "layer_overlay_consts.svh"
`default_nettype none

module layer_overlay_pixel_scroll (
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        frame_start,
   input  wire logic        line_start,
   input  wire logic        byte_strobe,
   input  wire logic [7:0]  layer_data_0,
   input  wire logic [7:0]  layer_data_1,
   input  wire logic [7:0]  layer_data_2,
   input  wire logic [15:0] block_start_address_0,
   input  wire logic [15:0] block_start_address_1,
   input  wire logic [15:0] block_start_address_2,
   input  wire logic [7:0]  address_pitch,
   input  wire logic [7:0]  fine_pixel_scroll_command,
   input  wire logic [7:0]  layer_overlay_command,
   input  wire logic [1:0]  layer_attr_0,
   input  wire logic [1:0]  layer_attr_1,
   input  wire logic [1:0]  layer_attr_2,
   input  wire logic [1:0]  bpp_mode,
   output logic      [15:0] fetch_addr_0,
   output logic      [15:0] fetch_addr_1,
   output logic      [15:0] fetch_addr_2,
   output logic      [7:0]  pixel_byte,
   output logic             pixel_valid,
   output logic      [2:0]  active_fine_scroll
);

   logic [7:0]  data_w     [3];
   logic [15:0] start_w    [3];
   logic [1:0]  attr_w     [3];
   logic [15:0] addr_q     [3];
   logic [15:0] line_base_q[3];
   logic [7:0]  gated_w    [3];

   logic [2:0]  fine_q;
   logic [1:0]  mix_q;
   logic [5:0]  slow_cnt_q;
   logic [5:0]  fast_cnt_q;
   logic        slow_phase_q;
   logic        fast_phase_q;
   logic [7:0]  prev_q;
   logic [7:0]  pixel_q;
   logic        valid_q;
   logic [7:0]  composed_w;
   logic [15:0] window_w;

   assign data_w[0]  = layer_data_0;
   assign data_w[1]  = layer_data_1;
   assign data_w[2]  = layer_data_2;
   assign start_w[0] = block_start_address_0;
   assign start_w[1] = block_start_address_1;
   assign start_w[2] = block_start_address_2;
   assign attr_w[0]  = layer_attr_0;
   assign attr_w[1]  = layer_attr_1;
   assign attr_w[2]  = layer_attr_2;

   // True while a layer with this attribute is to be shown.
   function automatic logic layer_visible(
      input logic [1:0] attr,
      input logic       slow_phase,
      input logic       fast_phase
   );
      case (attr)
         layer_overlay_pkg::ATTR_OFF:        layer_visible = 1'b0;
         layer_overlay_pkg::ATTR_ON:         layer_visible = 1'b1;
         layer_overlay_pkg::ATTR_FLASH_SLOW: layer_visible = slow_phase;
         layer_overlay_pkg::ATTR_FLASH_FAST: layer_visible = fast_phase;
         default:                            layer_visible = 1'b0;
      endcase
   endfunction

   // Settings are taken only at frame start so a scroll step made in the
   // middle of a frame cannot tear the picture between two lines.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fine_q <= `FINE_SCROLL_RESET;
      end else if (frame_start) begin
         if (bpp_mode == layer_overlay_pkg::BPP_1) begin
            fine_q <= fine_pixel_scroll_command[`FINE_SCROLL_LSB +:
                                                `FINE_SCROLL_WIDTH];
         end else begin
            fine_q <= `FINE_SCROLL_RESET;
         end
      end
   end

   // Mix bits are gathered by position, so the logic does not depend on
   // where the command byte keeps them.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mix_q <= `LAYER_MIX_RESET;
      end else if (frame_start) begin
         mix_q <= {layer_overlay_command[`LAYER_MIX_HIGH_BIT_POS],
                   layer_overlay_command[`LAYER_MIX_LOW_BIT_POS]};
      end
   end

   // Flash timebase, advanced once per frame.
   // Phases start visible so a flashing layer shows at once after reset.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         slow_cnt_q   <= `FLASH_COUNT_RESET;
         fast_cnt_q   <= `FLASH_COUNT_RESET;
         slow_phase_q <= 1'b1;
         fast_phase_q <= 1'b1;
      end else if (frame_start) begin
         if (slow_cnt_q == `FLASH_SLOW_HALF - 6'h01) begin
            slow_cnt_q   <= `FLASH_COUNT_RESET;
            slow_phase_q <= ~slow_phase_q;
         end else begin
            slow_cnt_q <= slow_cnt_q + 6'h01;
         end
         if (fast_cnt_q == `FLASH_FAST_HALF - 6'h01) begin
            fast_cnt_q   <= `FLASH_COUNT_RESET;
            fast_phase_q <= ~fast_phase_q;
         end else begin
            fast_cnt_q <= fast_cnt_q + 6'h01;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_layer
         // Each address step is one byte, that is eight pixels on screen.
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               addr_q[gi]      <= `ADDR_RESET;
               line_base_q[gi] <= `ADDR_RESET;
            end else if (frame_start) begin
               addr_q[gi]      <= start_w[gi];
               line_base_q[gi] <= start_w[gi];
            end else if (line_start) begin
               addr_q[gi]      <= line_base_q[gi] + {8'h00, address_pitch};
               line_base_q[gi] <= line_base_q[gi] + {8'h00, address_pitch};
            end else if (byte_strobe) begin
               addr_q[gi] <= addr_q[gi] + 16'h0001;
            end
         end

         assign gated_w[gi] = layer_visible(attr_w[gi], slow_phase_q,
                                            fast_phase_q)
                              ? data_w[gi] : 8'h00;
      end
   endgenerate

   // The fourth mix code repeats OR, so an unused setting still shows
   // every layer rather than a blank screen.
   always_comb begin
      case (mix_q)
         layer_overlay_pkg::MIX_OR:
            composed_w = gated_w[0] | gated_w[1] | gated_w[2];
         layer_overlay_pkg::MIX_XOR:
            composed_w = gated_w[0] ^ gated_w[1] ^ gated_w[2];
         layer_overlay_pkg::MIX_AND:
            composed_w = gated_w[0] & gated_w[1] & gated_w[2];
         layer_overlay_pkg::MIX_PRI_OR:
            composed_w = gated_w[0] | gated_w[1] | gated_w[2];
         default:
            composed_w = 8'h00;
      endcase
   end

   // The window spans the previous and current composed bytes, so one
   // shifter serves every layer and the output lags the fetch by a byte.
   assign window_w = {prev_q, composed_w} << fine_q;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prev_q <= 8'h00;
      end else if (frame_start || line_start) begin
         prev_q <= 8'h00;
      end else if (byte_strobe) begin
         prev_q <= composed_w;
      end
   end

   // A strobe that meets a frame or line start is refused, because the
   // fetch addresses have not yet been pointed at a valid byte for it.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pixel_q <= 8'h00;
         valid_q <= 1'b0;
      end else if (byte_strobe && !frame_start && !line_start) begin
         pixel_q <= window_w[15:8];
         valid_q <= 1'b1;
      end else begin
         valid_q <= 1'b0;
      end
   end

   // Outputs are plain copies of registers, so nothing combinational
   // reaches a pin and the fetch side never sees a glitch.
   assign fetch_addr_0       = addr_q[0];
   assign fetch_addr_1       = addr_q[1];
   assign fetch_addr_2       = addr_q[2];
   assign pixel_byte         = pixel_q;
   assign pixel_valid        = valid_q;
   assign active_fine_scroll = fine_q;

endmodule

`default_nettype wire

//--- tb/layer_overlay_checker.sv
// Port-level assertions for the layer overlay and fine scroll block.
// Assumes one clock domain with an asynchronous active low reset.
`timescale 1ns/100ps
`default_nettype none
module layer_overlay_checker (
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic        frame_start,
   input wire logic        line_start,
   input wire logic        byte_strobe,
   input wire logic [15:0] block_start_address_0,
   input wire logic [7:0]  fine_pixel_scroll_command,
   input wire logic [1:0]  bpp_mode,
   input wire logic [15:0] fetch_addr_0,
   input wire logic        pixel_valid,
   input wire logic [2:0]  active_fine_scroll
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic take;
   assign take = byte_strobe && !frame_start && !line_start;
   fine_latch_a: assert property (frame_start && bpp_mode == 2'h0 |=>
      active_fine_scroll == $past(fine_pixel_scroll_command[2:0]))
      else $error("fine offset not latched");
   fine_block_a: assert property (frame_start && bpp_mode != 2'h0 |=>
      active_fine_scroll == 3'h0) else $error("fine offset in multi-bit mode");
   fine_hold_a: assert property (!frame_start |=>
      $stable(active_fine_scroll)) else $error("fine offset moved mid frame");
   start_load_a: assert property (frame_start |=>
      fetch_addr_0 == $past(block_start_address_0)) else $error("bad start");
   addr_step_a: assert property (take |=>
      fetch_addr_0 == $past(fetch_addr_0) + 16'h0001) else $error("no step");
   addr_hold_a: assert property (!frame_start && !line_start && !byte_strobe
      |=> $stable(fetch_addr_0)) else $error("address drifted");
   valid_pulse_a: assert property (take |=> pixel_valid ##1
      (pixel_valid == $past(take))) else $error("valid pulse wrong");
   output_refuse_a: assert property (!take |=> !pixel_valid)
      else $error("output without accepted byte");
endmodule
bind layer_overlay_pixel_scroll
   layer_overlay_checker layer_overlay_checker_inst (
   .clock, .reset_n, .frame_start, .line_start, .byte_strobe,
   .block_start_address_0, .fine_pixel_scroll_command, .bpp_mode,
   .fetch_addr_0, .pixel_valid, .active_fine_scroll);
`default_nettype wire

//--- tb/layer_overlay_host_model.sv
// Host model that steps the fine scroll and start address once a frame.
// Assumes frame_start falls just after the edge that sampled it.
`timescale 1ns/100ps
`default_nettype none
module layer_overlay_host_model #(
   parameter logic [15:0] ADDR_LIMIT = 16'h0003
) (
   input  wire logic        frame_start,
   input  wire logic        scroll_right,
   output logic      [7:0]  fine_pixel_scroll_command,
   output logic      [15:0] block_start_address_0
);
   initial begin
      fine_pixel_scroll_command = 8'h00;
      block_start_address_0 = 16'h0001;
   end
   // Stepping after the sampling edge keeps each frame's settings steady.
   always @(negedge frame_start) begin
      if (!scroll_right) begin
         if (fine_pixel_scroll_command != 8'h07)
            fine_pixel_scroll_command++;
         else if (block_start_address_0 != ADDR_LIMIT) begin
            fine_pixel_scroll_command = 8'h00;
            block_start_address_0++;
         end
      end else if (fine_pixel_scroll_command != 8'h00)
         fine_pixel_scroll_command--;
      else if (block_start_address_0 != 16'h0000) begin
         fine_pixel_scroll_command = 8'h07;
         block_start_address_0--;
      end
   end
endmodule
`default_nettype wire

//--- tb/layer_overlay_pixel_scroll_tb_top.sv
// Self-checking bench: frames of random bytes against a queue model.
// Assumes the design's one-cycle output latency and frame-latched settings.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module layer_overlay_pixel_scroll_tb_top;
   logic clock = 1'b0, reset_n = 1'b0, frame_start = 1'b0, line_start = 1'b0;
   logic byte_strobe = 1'b0, scroll_right = 1'b0, pixel_valid;
   logic [7:0] layer_data_0 = 8'h00, layer_data_1 = 8'h00;
   logic [7:0] layer_data_2 = 8'h00;
   logic [7:0] address_pitch = 8'h28, layer_overlay_command = 8'h00;
   logic [7:0] fine_pixel_scroll_command, pixel_byte, r = 8'h1F, prev;
   logic [1:0] layer_attr_0 = 2'h1, layer_attr_1 = 2'h1;
   logic [1:0] layer_attr_2 = 2'h1;
   logic [1:0] bpp_mode = 2'h0, mx;
   logic [15:0] block_start_address_0, fetch_addr_0, w;
   logic [15:0] fetch_addr_1, fetch_addr_2, sa;
   wire logic [15:0] block_start_address_1 = block_start_address_0 + 16'h0100;
   wire logic [15:0] block_start_address_2 = block_start_address_0 + 16'h0200;
   logic [2:0] active_fine_scroll, f;
   logic was_fs = 1'b0, was_ls = 1'b0;
   logic [7:0] q[$];
   int n_fail = 0, samples_checked = 0, k;
   always #25 clock = ~clock;
   layer_overlay_pixel_scroll layer_overlay_pixel_scroll_inst (.clock,
      .reset_n, .frame_start, .line_start, .byte_strobe, .layer_data_0,
      .layer_data_1, .layer_data_2, .block_start_address_0,
      .block_start_address_1, .block_start_address_2, .address_pitch,
      .fine_pixel_scroll_command, .layer_overlay_command, .layer_attr_0,
      .layer_attr_1, .layer_attr_2, .bpp_mode, .fetch_addr_0,
      .fetch_addr_1, .fetch_addr_2, .pixel_byte, .pixel_valid,
      .active_fine_scroll);
   layer_overlay_host_model layer_overlay_host_model_inst (.frame_start,
      .scroll_right, .fine_pixel_scroll_command, .block_start_address_0);
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // Flash half periods are 17 frames slow and 2 frames fast; both phases
   // start visible at reset and toggle at a frame start.
   function automatic logic [7:0] gate(input logic [7:0] d,
                                       input logic [1:0] a);
      logic on;
      on = (a == 2'h1) || (a == 2'h2 && (k + 1) / 17 % 2 == 0)
         || (a == 2'h3 && (k + 1) / 2 % 2 == 0);
      return on ? d : 8'h00;
   endfunction
   task automatic step(input logic fs, input logic ls, input logic bs);
      logic [7:0] g0, g1, g2;
      @(posedge clock);
      #2;
      if (was_fs) begin
         `CHK(fetch_addr_0, sa)
         `CHK(fetch_addr_1, sa + 16'h0100)
         `CHK(fetch_addr_2, sa + 16'h0200)
         `CHK(active_fine_scroll, f)
      end
      if (was_ls)
         `CHK(fetch_addr_0, sa + 16'(address_pitch))
      r = lfsr(r);
      if (fs) begin
         layer_overlay_command = 8'(k % 4);
         bpp_mode = (k % 5 == 4) ? 2'h1 : (k % 7 == 6) ? 2'h2 : 2'h0;
         layer_attr_0 = r[1:0];
         layer_attr_1 = r[3:2];
         layer_attr_2 = r[5:4];
         sa = block_start_address_0;
         scroll_right = (k >= 24);
         f = (bpp_mode == 2'h0) ? fine_pixel_scroll_command[2:0] : 3'h0;
         mx = layer_overlay_command[1:0];
      end
      if (fs || ls)
         prev = 8'h00;
      layer_data_0 = r;
      layer_data_1 = (mx == 2'h1) ? 8'hFF : lfsr(r);
      layer_data_2 = ~r;
      frame_start = fs;
      line_start = ls;
      byte_strobe = bs;
      was_fs = fs;
      was_ls = ls && !fs;
      if (bs && !fs && !ls) begin
         g0 = gate(layer_data_0, layer_attr_0);
         g1 = gate(layer_data_1, layer_attr_1);
         g2 = gate(layer_data_2, layer_attr_2);
         g0 = (mx == 2'h1) ? g0 ^ g1 ^ g2 : (mx == 2'h2) ? g0 & g1 & g2
            : g0 | g1 | g2;
         w = {prev, g0} << f;
         q.push_back(w[15:8]);
         prev = g0;
      end
   endtask
   always @(posedge clock) begin
      #1;
      if (pixel_valid === 1'b1)
         `CHK(pixel_byte, (q.size() > 0) ? q.pop_front() : 8'hXX)
   end
   task automatic print_verdict();
      $display("checked %0d, failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #(50 * 4000);
      n_fail++;
      print_verdict();
   end
   initial begin
      repeat (20) @(posedge clock);
      #2 reset_n = 1'b1;
      for (k = 0; k < 32; k++) begin
         step(1'b1, 1'b0, 1'b1);
         repeat (6) step(1'b0, 1'b0, 1'b1);
         step(1'b0, 1'b1, 1'b1);
         repeat (4) step(1'b0, 1'b0, 1'b1);
         repeat (2) step(1'b0, 1'b0, 1'b0);
         $display("frame %0d done", k);
      end
      `CHK(q.size(), 0)
      print_verdict();
   end
endmodule
`default_nettype wire
